// *** core/calu_top.sv ***
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module calu_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Operands and carry
	input wire logic [15:0] A_IN,
	input wire logic [15:0] B_IN,
	input wire logic CARRY_IN,
	// Datapath control
	input wire logic [2:0] FUNCTION_SELECT,
	input wire logic A_REG_LOAD_LOW,
	input wire logic B_REG_LOAD_LOW,
	input wire logic RESULT_REG_LOAD_LOW,
	input wire logic OPERAND_REG_BYPASS,
	input wire logic RESULT_REG_BYPASS,
	input wire logic A_OPERAND_SEL,
	input wire logic B_OPERAND_SEL,
	// Results
	output logic [15:0] F_OUT,
	output calu_pkg::calu_status_type STATUS_OUT
);
	import calu_pkg::*;

	logic [15:0] a_reg_r;
	logic [15:0] a_reg_nxt;
	logic [15:0] b_reg_r;
	logic [15:0] b_reg_nxt;
	logic [15:0] result_r;
	logic [15:0] result_nxt;
	logic freeze_r;
	logic freeze_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [15:0] a_src;
	logic [15:0] b_src;
	logic [15:0] core_a;
	logic [15:0] core_b;
	logic [15:0] core_f;
	calu_status_type core_status;
	logic apb_setup;
	logic apb_access;
	logic addr_hit;

	// Decode used by the error answer; read data compares the address itself
	function automatic logic calu_mapped(input logic [11:0] addr);
		return (addr == CALU_OFS_CTRL) || (addr == CALU_OFS_STATUS);
	endfunction

	// APB phases
	assign apb_setup = PSEL & ~PENABLE;
	assign apb_access = PSEL & PENABLE;
	assign addr_hit = calu_mapped(PADDR);

	// Operand and result register next values; freeze lets software hold a result
	always_comb begin
		a_reg_nxt = a_reg_r;
		b_reg_nxt = b_reg_r;
		result_nxt = result_r;
		if (!A_REG_LOAD_LOW && !freeze_r) begin
			a_reg_nxt = A_IN;
		end
		if (!B_REG_LOAD_LOW && !freeze_r) begin
			b_reg_nxt = B_IN;
		end
		if (!RESULT_REG_LOAD_LOW && !freeze_r) begin
			result_nxt = core_f;
		end
	end

	// Datapath registers
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			a_reg_r <= CALU_OPERAND_RST;
			b_reg_r <= CALU_OPERAND_RST;
			result_r <= CALU_RESULT_RST;
		end else begin
			a_reg_r <= a_reg_nxt;
			b_reg_r <= b_reg_nxt;
			result_r <= result_nxt;
		end
	end

	// Bypass picks live inputs; the registers still load behind it
	always_comb begin
		a_src = OPERAND_REG_BYPASS ? A_IN : a_reg_r;
		b_src = OPERAND_REG_BYPASS ? B_IN : b_reg_r;
	end

	// Operand select; feedback always uses the register, never the bypass path
	always_comb begin
		unique case ({B_OPERAND_SEL, A_OPERAND_SEL})
			2'h0: begin
				core_b = result_r;
				core_a = a_src;
			end
			2'h1: begin
				core_b = 16'h0000;
				core_a = a_src;
			end
			2'h2: begin
				core_b = b_src;
				core_a = 16'h0000;
			end
			2'h3: begin
				core_b = b_src;
				core_a = a_src;
			end
		endcase
	end

	// Arithmetic and logic core
	calu_core u_core (
		.op_a(core_a),
		.op_b(core_b),
		.carry_in(CARRY_IN),
		.function_select(FUNCTION_SELECT),
		.result(core_f),
		.status(core_status)
	);

	// Result pins; bypass trades a register stage for a longer path
	always_comb begin
		F_OUT = RESULT_REG_BYPASS ? core_f : result_r;
		STATUS_OUT = core_status;
	end

	// Register bus next values; read data is captured in setup for a zero-wait access
	always_comb begin
		freeze_nxt = freeze_r;
		rdata_nxt = rdata_r;
		if (apb_access && PWRITE && PADDR == CALU_OFS_CTRL) begin
			freeze_nxt = PWDATA[CALU_CTRL_FREEZE_BIT];
		end
		if (apb_setup && !PWRITE) begin
			rdata_nxt = CALU_RDATA_RST;
			if (PADDR == CALU_OFS_CTRL) begin
				rdata_nxt[CALU_CTRL_FREEZE_BIT] = freeze_r;
			end else if (PADDR == CALU_OFS_STATUS) begin
				rdata_nxt[15:0] = result_r;
				rdata_nxt[CALU_STAT_FLAGS_LSB +: 5] = core_status;
			end
		end
	end

	// Register bus state
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			freeze_r <= CALU_CTRL_FREEZE_RST;
			rdata_r <= CALU_RDATA_RST;
		end else begin
			freeze_r <= freeze_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Bus answers; unmapped addresses error in the access phase
	always_comb begin
		PREADY = 1'b1;
		PSLVERR = apb_access & ~addr_hit;
		PRDATA = rdata_r;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_clear_code: assert property ((FUNCTION_SELECT == CALU_FN_CLEAR)
		|-> (core_f == 16'h0000))
		else $error("clear code did not give zero");
	a_add_carry: assert property ((FUNCTION_SELECT == CALU_FN_ADD) |->
		({STATUS_OUT.c16, core_f} == ({1'b0, core_a} + {1'b0, core_b} + {16'h0000, CARRY_IN})))
		else $error("add result or carry wrong");
	a_sub_a_minus_b: assert property ((FUNCTION_SELECT == CALU_FN_A_NOTB
		&& CARRY_IN) |-> (core_f == 16'(core_a - core_b)))
		else $error("A minus B wrong");
	a_sub_b_minus_a: assert property ((FUNCTION_SELECT == CALU_FN_NOTA_B
		&& CARRY_IN) |-> (core_f == 16'(core_b - core_a)))
		else $error("B minus A wrong");
	a_logic_xor: assert property ((FUNCTION_SELECT == CALU_FN_XOR)
		|-> (core_f == (core_a ^ core_b)))
		else $error("xor result wrong");
	a_preset_code: assert property ((FUNCTION_SELECT == CALU_FN_PRESET) |->
		(core_f == 16'hffff && !STATUS_OUT.c16))
		else $error("preset result wrong");
	a_a_reg_hold: assert property ((A_REG_LOAD_LOW || freeze_r)
		|=> (a_reg_r == $past(a_reg_r)))
		else $error("A register changed while not loading");
	a_b_reg_load: assert property ((!B_REG_LOAD_LOW && !freeze_r)
		|=> (b_reg_r == $past(B_IN)))
		else $error("B register missed a load");
	a_bypass_path: assert property ((OPERAND_REG_BYPASS
		&& A_OPERAND_SEL && B_OPERAND_SEL) |-> (core_a == A_IN && core_b == B_IN))
		else $error("operand bypass not taken");
	// Feedback is checked in the same cycle, so a select change after a load cannot trip it
	a_feedback_acc: assert property ((!A_OPERAND_SEL && !B_OPERAND_SEL)
		|-> (core_b == result_r))
		else $error("accumulator feedback broken");
	a_zero_force: assert property ((A_OPERAND_SEL != B_OPERAND_SEL) |->
		(A_OPERAND_SEL ? core_b == 16'h0000 : core_a == 16'h0000))
		else $error("operand not forced to zero");
	a_result_out: assert property ((!RESULT_REG_LOAD_LOW && !freeze_r)
		|=> (result_r == $past(core_f)))
		else $error("result register missed a load");
	a_result_pins: assert property (F_OUT ==
		(RESULT_REG_BYPASS ? core_f : result_r))
		else $error("result pins show the wrong source");
	a_status_read: assert property ((apb_setup && !PWRITE
		&& PADDR == CALU_OFS_STATUS) |=> (PRDATA[15:0] == $past(result_r)))
		else $error("status read wrong");

	c_accumulate: cover property ((!A_OPERAND_SEL && !B_OPERAND_SEL && FUNCTION_SELECT == CALU_FN_ADD
		&& !RESULT_REG_LOAD_LOW) [*3]);
	c_subtract: cover property (FUNCTION_SELECT == CALU_FN_NOTA_B && CARRY_IN && STATUS_OUT.c16);
	c_full_bypass: cover property (OPERAND_REG_BYPASS && RESULT_REG_BYPASS && STATUS_OUT.ovf);
	c_apb_error: cover property (PSLVERR);

endmodule

`default_nettype wire

// *** core/calu_pkg.sv ***
`default_nettype none
package calu_pkg;

	// Datapath width of one slice
	localparam int CALU_DATA_W = 16;

	// Function select codes
	localparam logic [2:0] CALU_FN_CLEAR = 3'h0;
	localparam logic [2:0] CALU_FN_NOTA_B = 3'h1;
	localparam logic [2:0] CALU_FN_A_NOTB = 3'h2;
	localparam logic [2:0] CALU_FN_ADD = 3'h3;
	localparam logic [2:0] CALU_FN_XOR = 3'h4;
	localparam logic [2:0] CALU_FN_OR = 3'h5;
	localparam logic [2:0] CALU_FN_AND = 3'h6;
	localparam logic [2:0] CALU_FN_PRESET = 3'h7;

	// Register bus map, byte addresses
	localparam logic [11:0] CALU_OFS_CTRL = 12'h000;
	localparam logic [11:0] CALU_OFS_STATUS = 12'h004;
	localparam int CALU_CTRL_FREEZE_BIT = 0;
	localparam logic CALU_CTRL_FREEZE_RST = 1'b0;
	localparam int CALU_STAT_FLAGS_LSB = 16;

	// Reset values of the datapath registers and the read data register
	localparam logic [15:0] CALU_OPERAND_RST = 16'h0000;
	localparam logic [15:0] CALU_RESULT_RST = 16'h0000;
	localparam logic [31:0] CALU_RDATA_RST = 32'h0000_0000;

	// Cascade and status flags
	typedef struct packed {
		logic c16;
		logic prop;
		logic gen;
		logic ovf;
		logic zero;
	} calu_status_type;

	// Arithmetic codes are the only ones with carry chain meaning
	function automatic logic calu_is_arith(input logic [2:0] fsel);
		return (fsel == CALU_FN_NOTA_B) || (fsel == CALU_FN_A_NOTB) || (fsel == CALU_FN_ADD);
	endfunction

endpackage

`default_nettype wire

// *** core/calu_core.sv ***
`timescale 1ns/1ps
`default_nettype none

// Combinational arithmetic core with cascade outputs
module calu_core (
	// Operands
	input wire logic [15:0] op_a,
	input wire logic [15:0] op_b,
	input wire logic carry_in,
	// Control
	input wire logic [2:0] function_select,
	// Results
	output logic [15:0] result,
	output calu_pkg::calu_status_type status
);
	import calu_pkg::*;

	logic [15:0] in_a;
	logic [15:0] in_b;
	logic [16:0] sum;
	logic [16:0] gen_sum;

	// Operand inversion for the two subtract-style codes
	always_comb begin
		in_a = (function_select == CALU_FN_NOTA_B) ? ~op_a : op_a;
		in_b = (function_select == CALU_FN_A_NOTB) ? ~op_b : op_b;
		sum = {1'b0, in_a} + {1'b0, in_b} + {16'h0000, carry_in};
		gen_sum = {1'b0, in_a} + {1'b0, in_b};
	end

	// Function mux
	always_comb begin
		unique case (function_select)
			CALU_FN_CLEAR: result = 16'h0000;
			CALU_FN_NOTA_B, CALU_FN_A_NOTB, CALU_FN_ADD: result = sum[15:0];
			CALU_FN_XOR: result = op_a ^ op_b;
			CALU_FN_OR: result = op_a | op_b;
			CALU_FN_AND: result = op_a & op_b;
			CALU_FN_PRESET: result = 16'hffff;
		endcase
	end

	// Cascade flags; carry-type flags only mean something for arithmetic
	always_comb begin
		status.zero = (result == 16'h0000);
		status.c16 = calu_is_arith(function_select) & sum[16];
		status.gen = calu_is_arith(function_select) & gen_sum[16];
		status.prop = calu_is_arith(function_select) & (&(in_a | in_b));
		status.ovf = calu_is_arith(function_select) & (in_a[15] == in_b[15])
			& (sum[15] != in_a[15]);
	end

endmodule

`default_nettype wire

// *** testbench/calu_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host datapath logic that feeds the unit its operands and controls
module calu_host (
	// Clock
	input wire logic clk,
	// Operands and controls toward the unit
	output logic [15:0] a,
	output logic [15:0] b,
	output logic cin,
	output logic [2:0] fsel,
	output logic [2:0] load_n,
	output logic [1:0] byp,
	output logic [1:0] sel
);
	// Quiet start: nothing loads until a step asks for it
	initial begin
		a = 16'h0000;
		b = 16'h0000;
		cin = 1'b0;
		fsel = 3'h0;
		load_n = 3'h7;
		byp = 2'h0;
		sel = 2'h3;
	end
	// All pins change together just after an edge, so the unit never sees a mix
	task automatic step(input logic [15:0] na, nb, input logic nc, input logic [2:0] nf, nl,
		input logic [1:0] ny, ns);
		@(posedge clk);
		a <= na;
		b <= nb;
		cin <= nc;
		fsel <= nf;
		load_n <= nl;
		byp <= ny;
		sel <= ns;
	endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import calu_pkg::*;
	// Clock, reset and register bus
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	// Datapath pins, load_n is {F,B,A}, byp is {F,operands}, sel is {B,A}
	logic [15:0] a_in, b_in, f_out;
	logic cin;
	logic [2:0] fsel, load_n;
	logic [1:0] byp, sel;
	calu_status_type st;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	calu_host i_calu_host (.clk(clk), .a(a_in), .b(b_in), .cin(cin), .fsel(fsel),
		.load_n(load_n), .byp(byp), .sel(sel));
	calu_top i_calu_top (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .A_IN(a_in), .B_IN(b_in), .CARRY_IN(cin), .FUNCTION_SELECT(fsel),
		.A_REG_LOAD_LOW(load_n[0]), .B_REG_LOAD_LOW(load_n[1]),
		.RESULT_REG_LOAD_LOW(load_n[2]), .OPERAND_REG_BYPASS(byp[0]),
		.RESULT_REG_BYPASS(byp[1]), .A_OPERAND_SEL(sel[0]), .B_OPERAND_SEL(sel[1]),
		.F_OUT(f_out), .STATUS_OUT(st));
	// 5 ns clock; a hung wait is cut off long after the last scenario
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Reference result with carry out on top; carry only means something for sums
	function automatic logic [16:0] model(input logic [2:0] f, input logic [15:0] a, b);
		case (f)
			CALU_FN_CLEAR: return 17'h00000;
			CALU_FN_NOTA_B: return {1'b0, ~a} + {1'b0, b};
			CALU_FN_A_NOTB: return {1'b0, a} + {1'b0, ~b};
			CALU_FN_ADD: return {1'b0, a} + {1'b0, b};
			CALU_FN_XOR: return {1'b0, a ^ b};
			CALU_FN_OR: return {1'b0, a | b};
			CALU_FN_AND: return {1'b0, a & b};
			default: return 17'h0ffff;
		endcase
	endfunction
	// One host step, then compare carry out and result once they settle
	task automatic op(input logic [15:0] a, b, input logic c, input logic [2:0] f, l,
		input logic [1:0] y, s, input logic [16:0] e);
		i_calu_host.step(a, b, c, f, l, y, s);
		#1;
		chk({15'h0000, st.c16, f_out}, {15'h0000, e});
	endtask
	// APB master: hold the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_funcs();
		for (int k = 0; k < 8; k++)
			op(16'h3c5a, 16'h0ff0, 1'b0, 3'(k), 3'h7, 2'h3, 2'h3,
				model(3'(k), 16'h3c5a, 16'h0ff0));
	endtask
	task automatic t_sub();
		op(16'h0005, 16'h0003, 1'b1, CALU_FN_A_NOTB, 3'h7, 2'h3, 2'h3, 17'h10002);
		op(16'h0005, 16'h0003, 1'b1, CALU_FN_NOTA_B, 3'h7, 2'h3, 2'h3, 17'h0fffe);
		op(16'hffff, 16'h0001, 1'b0, CALU_FN_ADD, 3'h7, 2'h3, 2'h3, 17'h10000);
		chk({27'h0, st}, 32'h0000_001d);
		// Signed overflow without carry; every flag is checked, not just zero
		op(16'h7fff, 16'h0001, 1'b0, CALU_FN_ADD, 3'h7, 2'h3, 2'h3, 17'h08000);
		chk({27'h0, st}, 32'h0000_0002);
	endtask
	// Operand registers load only while their load is low; bypass shows live inputs
	task automatic t_regs();
		op(16'h1111, 16'h2222, 1'b0, CALU_FN_ADD, 3'h4, 2'h2, 2'h3, 17'h00000);
		op(16'h0f0f, 16'h0f0f, 1'b0, CALU_FN_ADD, 3'h7, 2'h2, 2'h3, 17'h03333);
		op(16'h0f0f, 16'h0f0f, 1'b0, CALU_FN_ADD, 3'h7, 2'h3, 2'h3, 17'h01e1e);
		op(16'h0f0f, 16'h0f0f, 1'b0, CALU_FN_ADD, 3'h3, 2'h0, 2'h3, 17'h00000);
		op(16'h0f0f, 16'h0f0f, 1'b0, CALU_FN_ADD, 3'h6, 2'h0, 2'h3, 17'h03333);
		op(16'h0f0f, 16'h0f0f, 1'b0, CALU_FN_ADD, 3'h7, 2'h0, 2'h3, 17'h03333);
		op(16'h0f0f, 16'h0f0f, 1'b0, CALU_FN_ADD, 3'h7, 2'h2, 2'h3, 17'h03131);
	endtask
	// Feedback of the result register and forcing of either operand to zero
	task automatic t_accum();
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h7, 2'h3, 2'h0, 17'h03334);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h7, 2'h3, 2'h1, 17'h00001);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h7, 2'h3, 2'h2, 17'h00100);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h3, 2'h1, 2'h0, 17'h03333);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h3, 2'h1, 2'h0, 17'h03334);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h7, 2'h1, 2'h0, 17'h03335);
	endtask
	// Freeze through the control word holds the result; unmapped reads fail
	task automatic t_apb();
		apb(1'b0, CALU_OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, CALU_OFS_CTRL, 32'h1);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h3, 2'h1, 2'h0, 17'h03335);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h7, 2'h1, 2'h0, 17'h03335);
		apb(1'b0, CALU_OFS_STATUS, 32'h0);
		chk(rd, 32'h0000_3335);
		apb(1'b0, 12'h008, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, CALU_OFS_CTRL, 32'h0);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h3, 2'h1, 2'h0, 17'h03335);
		op(16'h0001, 16'h0100, 1'b0, CALU_FN_ADD, 3'h7, 2'h1, 2'h0, 17'h03336);
	endtask
	// Reset for six cycles, then every scenario in turn
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_funcs();
		t_sub();
		t_regs();
		t_accum();
		t_apb();
		summarize();
	end
endmodule
`default_nettype wire
